// *** bench/tbaf_properties.sv ***
// port-level checks for the type b framer
`timescale 1ns/1ns
`default_nettype none
module tbaf_properties (
	input wire clk_i, // clock
	input wire srst_i, // sync reset
	input wire rx_end_i, // frame end
	input wire [7:0] tx_data_o, // tx byte
	input wire tx_valid_o, // tx offered
	input wire tx_ready_i, // tx taken
	input wire active_o, // session open
	input wire [31:0] attr_param_o, // attrib params
	input wire attr_ok_o, // attrib accepted
	input wire guard_o // guard window
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (srst_i);
	// an answer starts two cycles after a frame end
	sequence s_start;
		$rose(tx_valid_o) ##0 $past(rx_end_i, 2);
	endsequence
	chk_atqb_head: assert property (s_start |-> tx_data_o == 8'h50)
		else $error("answer does not open with 50");
	chk_tx_hold: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o))
		else $error("stalled byte lost");
	chk_ok_pulse: assert property (attr_ok_o |=> !attr_ok_o)
		else $error("accept pulse too long");
	chk_ok_cause: assert property (attr_ok_o |-> $past(rx_end_i))
		else $error("accept not after frame end");
	chk_ok_active: assert property (attr_ok_o |-> active_o)
		else $error("accept without session");
	chk_active_cause: assert property ($rose(active_o) |-> attr_ok_o)
		else $error("session opened without accept");
	chk_param_cause: assert property ($changed(attr_param_o) |-> attr_ok_o)
		else $error("params moved without accept");
	chk_guard_min: assert property ($rose(guard_o) |-> guard_o [*8])
		else $error("guard window too short");
	chk_guard_quiet: assert property (guard_o |-> !$rose(tx_valid_o))
		else $error("answer started inside guard window");
endmodule // tbaf_properties
bind tbaf_framer tbaf_properties u_props (.clk_i(clk_i), .srst_i(srst_i), .rx_end_i(rx_end_i),
	.tx_data_o(tx_data_o), .tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready_i), .active_o(active_o),
	.attr_param_o(attr_param_o), .attr_ok_o(attr_ok_o), .guard_o(guard_o));
`default_nettype wire

// *** bench/tbaf_reader_model.sv ***
// reader-side model: sends frames, sinks the tag's answer
`timescale 1ns/1ns
`default_nettype none
module tbaf_reader_model #(
	parameter int G = 20
) (
	input wire logic clk_i, // clock
	output logic [7:0] rx_data_o, // byte to tag
	output logic rx_valid_o, // byte strobe
	output logic rx_end_o, // frame end
	input wire logic [7:0] tx_data_i, // byte from tag
	input wire logic tx_valid_i, // byte offered
	output logic tx_ready_o // byte taken
);
	logic [7:0] q[$];
	logic stall = 1'b0;
	initial
	begin
		{rx_data_o, rx_valid_o, rx_end_o} = 10'h0;
	end
	// sink side, stalls on request
	always @(negedge clk_i)
		tx_ready_o <= !stall;
	always @(posedge clk_i)
		if (tx_valid_i && tx_ready_o)
			q.push_back(tx_data_i);
	function automatic logic [15:0] crc_b(input logic [7:0] b[$]);
		logic [15:0] c;
		c = 16'hffff;
		foreach (b[i])
		begin
			c = c ^ {8'h00, b[i]};
			repeat (8) c = c[0] ? (c >> 1) ^ 16'h8408 : c >> 1;
		end
		return ~c;
	endfunction
	task automatic send(input logic [7:0] f[$], input logic bad);
		logic [15:0] c;
		c = crc_b(f) ^ {15'h0, bad};
		f.push_back(c[7:0]);
		f.push_back(c[15:8]);
		foreach (f[i])
		begin
			@(negedge clk_i);
			rx_data_o = f[i];
			rx_valid_o = 1'b1;
		end
		@(negedge clk_i);
		{rx_valid_o, rx_end_o} = 2'b01;
		rx_data_o = ~rx_data_o; // released line shows junk
		@(negedge clk_i);
		rx_end_o = 1'b0;
	endtask
	task automatic rest;
		repeat (G + 4) @(negedge clk_i);
	endtask
endmodule // tbaf_reader_model
`default_nettype wire

// *** bench/typeb_atqb_attrib_framer_test.sv ***
// self-checking bench for the type b framer
`timescale 1ns/1ns
`default_nettype none
module typeb_atqb_attrib_framer_test;
	localparam int G = 20;
	logic clk_i = 1'b0;
	logic srst_i = 1'b1;
	logic [31:0] pupi = 32'ha1b2c3d4;
	logic [3:0] fwi = 4'h7;
	logic [7:0] rx_data, tx_data;
	logic rx_valid, rx_end, tx_valid, tx_ready, active, attr_ok, guard;
	logic [31:0] attr_param;
	int miscompares = 0;
	int check_count = 0;
	int oks = 0;
	always #10 clk_i = ~clk_i;
	always @(posedge clk_i)
		if (attr_ok === 1'b1)
			oks++;
	tbaf_framer #(.GUARD_CYC(G)) u_dut (.clk_i(clk_i), .srst_i(srst_i), .pupi_i(pupi), .fwi_i(fwi),
		.rx_data_i(rx_data), .rx_valid_i(rx_valid), .rx_end_i(rx_end), .tx_data_o(tx_data),
		.tx_valid_o(tx_valid), .tx_ready_i(tx_ready), .active_o(active), .attr_param_o(attr_param),
		.attr_ok_o(attr_ok), .guard_o(guard));
	tbaf_reader_model #(.G(G)) u_rdr (.clk_i(clk_i), .rx_data_o(rx_data), .rx_valid_o(rx_valid),
		.rx_end_o(rx_end), .tx_data_i(tx_data), .tx_valid_i(tx_valid), .tx_ready_o(tx_ready));
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
		check_count++;
		if (got !== exp)
		begin
			miscompares++;
			$display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic t_drop;
		u_rdr.send('{8'h05, 8'h00, 8'h00}, 1'b1);
		u_rdr.send('{8'h06, 8'h00, 8'h00}, 1'b0);
		u_rdr.send('{8'h1d, ~pupi[31:24], pupi[23:16], pupi[15:8], pupi[7:0], 8'h00, 8'h08, 8'h01, 8'h00}, 1'b0);
		repeat (20) @(negedge clk_i);
		cmp(u_rdr.q.size(), 0, "bad frame answered");
		cmp(oks, 0, "foreign id accepted");
		cmp(active, 0, "session opened");
		$display("test drop done");
	endtask
	task automatic t_atqb(input logic [7:0] prm);
		logic [7:0] e[$];
		logic [15:0] c;
		int n;
		u_rdr.stall = 1'b1;
		u_rdr.send('{8'h05, 8'h00, prm}, 1'b0);
		repeat (20) @(negedge clk_i);
		cmp(tx_data, 8'h50, "held head");
		cmp(tx_valid, 1'b1, "held valid");
		u_rdr.stall = 1'b0;
		n = 0;
		while (u_rdr.q.size() < 14 && n < 60)
		begin
			@(negedge clk_i);
			n++;
		end
		e = '{8'h50, pupi[31:24], pupi[23:16], pupi[15:8], pupi[7:0], 8'h00, 8'h00, 8'h00, 8'h00,
			8'h91, 8'h81, {fwi, 4'h0}};
		c = u_rdr.crc_b(e);
		e.push_back(c[7:0]);
		e.push_back(c[15:8]);
		cmp(u_rdr.q.size(), 14, "answer length");
		cmp(guard, 1'b1, "guard window closed early");
		cmp(active, 1'b0, "session kept over request");
		foreach (e[i])
			cmp(u_rdr.q[i], e[i], "answer byte");
		u_rdr.q.delete();
		u_rdr.rest();
		cmp(guard, 1'b0, "guard window left open");
		$display("test answer done");
	endtask
	task automatic t_attrib;
		u_rdr.send('{8'h1d, pupi[31:24], pupi[23:16], pupi[15:8], pupi[7:0], 8'h00, 8'h08, 8'h01, 8'h00}, 1'b0);
		repeat (2) @(negedge clk_i);
		cmp(oks, 1, "accept pulses");
		cmp(active, 1, "session state");
		cmp(attr_param, 32'h00080100, "params");
		$display("test attrib done");
	endtask
	initial
	begin
		#100000;
		miscompares++;
		tally_and_finish();
	end
	initial
	begin
		repeat (10) @(negedge clk_i);
		srst_i = 1'b0;
		t_drop();
		t_atqb(8'h00);
		fwi = 4'hc;
		t_atqb(8'h08);
		t_attrib();
		t_atqb(8'h00);
		tally_and_finish();
	end
endmodule // typeb_atqb_attrib_framer_test
`default_nettype wire

// *** logic/tbaf_defines.vh ***
// constants for the type b atqb / attrib framer
`ifndef TBAF_DEFINES_VH
`define TBAF_DEFINES_VH
// command and response codes
`define TBAF_CMD_REQ 8'h05
`define TBAF_CMD_ATTR 8'h1d
`define TBAF_RSP_ATQB 8'h50
// protocol info bytes
`define TBAF_PI1 8'h91
`define TBAF_PI2_FSIZE 4'h8
`define TBAF_PI2_PTYPE 4'h1
`define TBAF_PI3_LOW 4'h0
`define TBAF_APP_BYTE 8'h00
// frame lengths in bytes, crc included
`define TBAF_REQ_LEN 4'h5
`define TBAF_ATQB_LEN 4'he
`define TBAF_ATTR_LEN 4'hb
// crc_b preset and reflected polynomial
`define TBAF_CRC_INIT 16'hffff
`define TBAF_CRC_POLY 16'h8408
// register value left after running data plus its own sent crc
`define TBAF_CRC_RESIDUE 16'hf0b8
// reader guard time after a response: 10 etu + 32/fs, in ns (106 kbps)
`define TBAF_GUARD_NS 32'd132145
`define TBAF_CLK_NS 32'd20
`define TBAF_GUARD_CYC ((`TBAF_GUARD_NS + `TBAF_CLK_NS - 32'd1) / `TBAF_CLK_NS)
`endif

// *** logic/tbaf_fifo.v ***
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ns
`default_nettype none
module tbaf_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 8,
	parameter AW = 3
) (
	input wire clk_i, // clock
	input wire srst_i, // sync reset
	input wire [WIDTH-1:0] in_data_i, // write data
	input wire in_valid_i, // write request
	output wire in_ready_o, // not full
	output wire [WIDTH-1:0] out_data_o, // read data
	output wire out_valid_o, // not empty
	input wire out_ready_i // read accept
);
	reg [WIDTH-1:0] mem_ff [0:DEPTH-1];
	reg [AW-1:0] wptr_ff;
	reg [AW-1:0] rptr_ff;
	reg [AW:0] cnt_ff;
	wire push;
	wire pop;

	// handshake terms
	assign in_ready_o = (cnt_ff != DEPTH[AW:0]);
	assign out_valid_o = (cnt_ff != {(AW+1){1'b0}});
	assign push = in_valid_i && in_ready_o;
	assign pop = out_valid_o && out_ready_i;
	assign out_data_o = mem_ff[rptr_ff];

	// storage write, no reset needed for data
	always @(posedge clk_i)
	begin
		if (push)
			mem_ff[wptr_ff] <= in_data_i;
	end

	// pointers and fill count
	always @(posedge clk_i)
	begin
		if (srst_i)
		begin
			wptr_ff <= {AW{1'b0}};
			rptr_ff <= {AW{1'b0}};
			cnt_ff <= {(AW+1){1'b0}};
		end
		else
		begin
			if (push)
				wptr_ff <= (wptr_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wptr_ff + 1'b1;
			if (pop)
				rptr_ff <= (rptr_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rptr_ff + 1'b1;
			if (push && !pop)
				cnt_ff <= cnt_ff + 1'b1;
			else if (pop && !push)
				cnt_ff <= cnt_ff - 1'b1;
		end
	end
endmodule // tbaf_fifo
`default_nettype wire

// *** logic/tbaf_framer.v ***
// atqb builder and attrib/request parser for a type b proximity tag
`timescale 1ns/1ns
`default_nettype none
`include "tbaf_defines.vh"
// Functional notes
// RL1: request code 0x05 (REQB or WUPB) with good crc triggers one ATQB.
// RL2: ATQB is 0x50, 4-byte id, 4 app bytes, 3 protocol bytes, crc.
// RL3: all four application data bytes are sent as zero.
// RL4: first protocol byte is 0x91, 106/212 kbps, same rate both ways.
// RL5: second protocol byte upper nibble is 1000b, 256-byte frames.
// RL6: second protocol byte lower nibble is 0001b, -4 protocol compliant.
// RL7: reader waits 10 etu plus 32 subcarrier periods after a response.
// RL8: third protocol byte upper nibble is fwi, lower nibble zero.
// RL9: third protocol byte bits 3-2 are 00b, proprietary app data.
// RL10: third protocol byte bits 1-0 are 00b, no nad or cid.
// RL11: a valid ATTRIB moves the tag to the command-processing state.
// RL12: ATTRIB is code, 4-byte id, four parameter bytes, 2-byte crc.
// RL13: ATTRIB code is 0x1d and its id must match our reported id.
// RL14: crc_b is computed over preceding bytes; bad-crc frames are dropped.
// RL15: ATQB bytes go out in field order, crc low then high.
module tbaf_framer #(
	parameter DEPTH = 8, // tx fifo depth
	parameter AW = 3, // tx fifo index width
	parameter GUARD_CYC = `TBAF_GUARD_CYC // reader guard time in cycles
) (
	input wire clk_i, // 50 mhz clock
	input wire srst_i, // sync reset, active high
	input wire [31:0] pupi_i, // card identifier
	input wire [3:0] fwi_i, // frame waiting time integer
	input wire [7:0] rx_data_i, // received byte
	input wire rx_valid_i, // received byte strobe
	input wire rx_end_i, // end of received frame pulse
	output wire [7:0] tx_data_o, // byte to transmit
	output wire tx_valid_o, // byte available
	input wire tx_ready_i, // modulator takes byte
	output reg active_o, // tag in command-processing state
	output reg [31:0] attr_param_o, // param1..4 of last accepted attrib
	output reg attr_ok_o, // one-cycle pulse on accepted attrib
	output reg guard_o // reader guard window running
);
	localparam ST_IDLE = 2'd0;
	localparam ST_SEND = 2'd1;
	reg [1:0] state_ff;
	reg [3:0] rx_cnt_ff;
	reg [3:0] tx_idx_ff;
	reg [15:0] rx_crc_ff;
	reg [15:0] tx_crc_ff;
	reg [7:0] rx_cmd_ff;
	reg [31:0] rx_id_ff;
	reg [31:0] rx_par_ff;
	reg [31:0] pupi_ff;
	reg [3:0] fwi_ff;
	reg [31:0] guard_cnt_ff;
	reg [7:0] nxt_tx_byte;
	wire fifo_in_ready;
	wire fifo_out_valid;
	wire fifo_push;
	wire tx_last;

	// one crc_b byte step, lsb first, reflected polynomial
	function [15:0] tbaf_crc_step;
		input [15:0] crc;
		input [7:0] data;
		integer i;
		reg [15:0] c;
		begin
			c = crc ^ {8'h00, data};
			for (i = 0; i < 8; i = i + 1)
				c = c[0] ? ((c >> 1) ^ `TBAF_CRC_POLY) : (c >> 1);
			tbaf_crc_step = c;
		end
	endfunction

	// ATQB byte selected by index
	always @*
	begin
		case (tx_idx_ff)
			// RL2: response code first
			4'h0: nxt_tx_byte = `TBAF_RSP_ATQB;
			4'h1: nxt_tx_byte = pupi_ff[31:24];
			4'h2: nxt_tx_byte = pupi_ff[23:16];
			4'h3: nxt_tx_byte = pupi_ff[15:8];
			4'h4: nxt_tx_byte = pupi_ff[7:0];
			// RL3: application data zero
			4'h5, 4'h6, 4'h7, 4'h8: nxt_tx_byte = `TBAF_APP_BYTE;
			// RL4: rate byte
			4'h9: nxt_tx_byte = `TBAF_PI1;
			// RL5: frame size nibble
			// RL6: protocol type nibble
			4'ha: nxt_tx_byte = {`TBAF_PI2_FSIZE, `TBAF_PI2_PTYPE};
			// RL8: fwi high, low nibble zero
			// RL9: adc bits zero
			// RL10: frame option bits zero
			4'hb: nxt_tx_byte = {fwi_ff, `TBAF_PI3_LOW};
			// RL15: crc low byte, then high
			4'hc: nxt_tx_byte = ~tx_crc_ff[7:0];
			4'hd: nxt_tx_byte = ~tx_crc_ff[15:8];
			default: nxt_tx_byte = 8'h00;
		endcase
	end

	// fifo decouples the builder from the modulator's byte pace
	assign fifo_push = (state_ff == ST_SEND);
	assign tx_last = (tx_idx_ff == `TBAF_ATQB_LEN - 4'h1);

	tbaf_fifo #(
		.WIDTH(8),
		.DEPTH(DEPTH),
		.AW(AW)
	) u_txq (
		.clk_i(clk_i),
		.srst_i(srst_i),
		.in_data_i(nxt_tx_byte),
		.in_valid_i(fifo_push),
		.in_ready_o(fifo_in_ready),
		.out_data_o(tx_data_o),
		.out_valid_o(fifo_out_valid),
		.out_ready_i(tx_ready_i)
	);
	assign tx_valid_o = fifo_out_valid;

	// -------------------------------------------------
	// receive side: field capture and crc check
	// -------------------------------------------------
	always @(posedge clk_i)
	begin
		if (srst_i)
		begin
			rx_cnt_ff <= 4'h0;
			rx_crc_ff <= `TBAF_CRC_INIT;
			rx_cmd_ff <= 8'h00;
			rx_id_ff <= 32'h0;
			rx_par_ff <= 32'h0;
		end
		else if (rx_end_i)
		begin
			rx_cnt_ff <= 4'h0;
			rx_crc_ff <= `TBAF_CRC_INIT;
		end
		else if (rx_valid_i)
		begin
			// RL14: running crc over all bytes, crc included
			rx_crc_ff <= tbaf_crc_step(rx_crc_ff, rx_data_i);
			if (rx_cnt_ff != 4'hf)
				rx_cnt_ff <= rx_cnt_ff + 4'h1;
			// RL12: code, identifier, four params
			if (rx_cnt_ff == 4'h0)
				rx_cmd_ff <= rx_data_i;
			else if (rx_cnt_ff <= 4'h4)
				rx_id_ff <= {rx_id_ff[23:0], rx_data_i};
			else if (rx_cnt_ff <= 4'h8)
				rx_par_ff <= {rx_par_ff[23:0], rx_data_i};
		end
	end

	// -------------------------------------------------
	// frame decision, transmit sequencing, guard time
	// -------------------------------------------------
	// RL14: fixed residue over data plus sent crc means the frame checked good
	wire crc_good = (rx_crc_ff == `TBAF_CRC_RESIDUE);
	// RL1: request frame recognised while not sending and outside the guard window
	wire req_hit = rx_end_i && crc_good && (rx_cnt_ff == `TBAF_REQ_LEN) &&
		(rx_cmd_ff == `TBAF_CMD_REQ) && (state_ff == ST_IDLE) && !guard_o;
	// RL13: attrib code and identifier match
	wire attr_hit = rx_end_i && crc_good && (rx_cnt_ff == `TBAF_ATTR_LEN) &&
		(rx_cmd_ff == `TBAF_CMD_ATTR) && (rx_id_ff == pupi_ff) && (state_ff == ST_IDLE);

	always @(posedge clk_i)
	begin
		if (srst_i)
		begin
			state_ff <= ST_IDLE;
			tx_idx_ff <= 4'h0;
			tx_crc_ff <= `TBAF_CRC_INIT;
			pupi_ff <= 32'h0;
			fwi_ff <= 4'h0;
			active_o <= 1'b0;
			attr_param_o <= 32'h0;
			attr_ok_o <= 1'b0;
			guard_o <= 1'b0;
			guard_cnt_ff <= 32'h0;
		end
		else
		begin
			attr_ok_o <= 1'b0;
			// identity and fwi are latched while idle with no session open so a frame is consistent
			if (state_ff == ST_IDLE && !active_o)
			begin
				pupi_ff <= pupi_i;
				fwi_ff <= fwi_i;
			end
			// RL7: guard window follows the last byte written into the tx fifo
			if (guard_cnt_ff != 32'h0)
				guard_cnt_ff <= guard_cnt_ff - 32'h1;
			guard_o <= (guard_cnt_ff > 32'h1);
			case (state_ff)
				ST_IDLE:
				begin
					// RL1: answer a request
					if (req_hit)
					begin
						state_ff <= ST_SEND;
						tx_idx_ff <= 4'h0;
						tx_crc_ff <= `TBAF_CRC_INIT;
						active_o <= 1'b0;
					end
					// RL11: accepted attrib enters command state
					else if (attr_hit)
					begin
						active_o <= 1'b1;
						attr_param_o <= rx_par_ff;
						attr_ok_o <= 1'b1;
					end
				end
				ST_SEND:
				begin
					if (fifo_in_ready)
					begin
						// RL14: crc over bytes before the crc field
						if (tx_idx_ff < 4'hc)
							tx_crc_ff <= tbaf_crc_step(tx_crc_ff, nxt_tx_byte);
						tx_idx_ff <= tx_idx_ff + 4'h1;
						if (tx_last)
						begin
							state_ff <= ST_IDLE;
							guard_cnt_ff <= GUARD_CYC;
						end
					end
				end
				default: state_ff <= ST_IDLE;
			endcase
		end
	end
endmodule // tbaf_framer
`default_nettype wire
